// >>> rtl/pin_select_pkg.sv
// Constants and carrier types for the remappable pin select block
package pin_select_pkg;
  // ==========================================================================
  // Sizes
  localparam int N_PINS      = 8;   // Physical remappable pins
  localparam int N_VIRT      = 6;   // Virtual remappable pins
  localparam int N_INT       = 14;  // Internal sources, index 0 is ground
  localparam int N_INPUTS    = 8;   // Remappable peripheral inputs
  localparam int N_PERIPH    = 8;   // Remappable peripheral outputs
  localparam int N_SEL_REGS  = 4;   // Two 8-bit fields per select register
  localparam int FIELD_W     = 8;
  localparam int REG_W       = 16;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_KEY     = 8'h04;
  localparam logic [7:0] OFS_PINS    = 8'h08;
  localparam logic [7:0] OFS_INSEL   = 8'h10;
  localparam logic [7:0] OFS_OUTSEL  = 8'h20;
  localparam logic [7:0] OFS_SEL_MSK = 8'hF3;  // Strips the select index bits
  localparam int         SEL_IDX_LSB = 2;

  // ==========================================================================
  // Fields, keys and reset values
  localparam int          LOCK_BIT     = 11;
  localparam logic [7:0]  KEY_FIRST    = 8'h55;
  localparam logic [7:0]  KEY_SECOND   = 8'hAA;
  localparam logic [15:0] INSEL_RESET  = 16'hFFFF;
  localparam logic [15:0] OUTSEL_RESET = 16'h0000;
  localparam logic [7:0]  OUT_NULL     = 8'h00;

  // ==========================================================================
  // Input index map
  localparam logic [7:0] IDX_INT_HI  = 8'h0D;
  localparam logic [7:0] IDX_PIN_LO  = 8'h20;
  localparam logic [7:0] IDX_PIN_HI  = 8'h27;
  localparam logic [7:0] IDX_VIRT_LO = 8'hAA;
  localparam logic [7:0] IDX_VIRT_HI = 8'hAF;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_KEY1  = 3'b010,
    SEQ_ARMED = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bus_phase_t;
endpackage : pin_select_pkg

// >>> rtl/remappable_pin_select.sv
// Remappable pin select: AHB-Lite register file, lock sequence and pin/input muxes
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps

// Behaviour
// R01: Route peripherals to any remappable pin
// R02: Remappable peripheral has no default pin
// R03: Fixed peripherals keep their default pin
// R04: Remapped function overrides other digital functions
// R05: Analog function always wins over remap
// R06: Dedicated-pad and analog modules not remapped
// R07: Locked select writes complete, change nothing
// R08: Lock is control bit 11, 1 blocks
// R09: Keys 0x55, 0xAA then lock write
// R10: Lock holds until next key sequence
// R11: Reset: inputs all ones, outputs zeros
// R12: Lock resets unlocked
// R13: Input fields are 8-bit pin indices
// R14: Software relocks after mapping
// R15: Software parks unused inputs and outputs
// R16: Six virtual pins act as real ones
// R17: Key writes must be consecutive writes
module remappable_pin_select (
  input  wire logic                                 hclk,
  input  wire logic                                 hresetn,
  input  wire logic                                 hsel,
  input  wire logic [31:0]                          haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [31:0]                          hwdata,
  input  wire logic                                 hready,
  output logic      [31:0]                          hrdata,
  output logic                                      hreadyout,
  output logic                                      hresp,
  input  wire logic [pin_select_pkg::N_PINS-1:0]    pin_in,
  output logic      [pin_select_pkg::N_PINS-1:0]    pin_out,
  output logic      [pin_select_pkg::N_PINS-1:0]    pin_oe,
  input  wire logic [pin_select_pkg::N_PINS-1:0]    default_out,
  input  wire logic [pin_select_pkg::N_PINS-1:0]    default_oe,
  input  wire logic [pin_select_pkg::N_PINS-1:0]    analog_en,
  input  wire logic [pin_select_pkg::N_VIRT-1:0]    virt_in,
  input  wire logic [pin_select_pkg::N_INT-1:0]     internal_sig,
  input  wire logic [pin_select_pkg::N_PERIPH-1:0]  periph_out,
  input  wire logic [pin_select_pkg::N_PERIPH-1:0]  periph_oe,
  output logic      [pin_select_pkg::N_INPUTS-1:0]  periph_in
);

  // ==========================================================================
  // Declarations
  pin_select_pkg::bus_phase_t  dp_reg;
  pin_select_pkg::seq_state_t  seq_reg;
  logic                        lock_reg;
  logic                        rd_wait_reg;
  logic [31:0]                 hrdata_reg;
  logic [15:0]                 insel_reg  [pin_select_pkg::N_SEL_REGS];
  logic [15:0]                 outsel_reg [pin_select_pkg::N_SEL_REGS];
  logic                        accept;
  logic                        wr_en;
  logic                        sel_hit_in;
  logic                        sel_hit_out;
  logic [1:0]                  sel_idx;
  logic [7:0]                  key_byte;
  logic [31:0]                 rdata_next;
  logic [pin_select_pkg::N_INPUTS-1:0] periph_in_next;
  logic [pin_select_pkg::N_PINS-1:0]   pin_out_next;
  logic [pin_select_pkg::N_PINS-1:0]   pin_oe_next;

  // Selects one 8-bit field out of a bank of two-field select registers
  function automatic logic [7:0] field_of(input logic [15:0] r, input int k);
    field_of = r[(k % 2) * pin_select_pkg::FIELD_W +: pin_select_pkg::FIELD_W];
  endfunction : field_of

  // Resolves an input index to a level; unlisted and reserved indices read low
  function automatic logic index_level(input logic [7:0] idx,
                                       input logic [pin_select_pkg::N_PINS-1:0] pins,
                                       input logic [pin_select_pkg::N_VIRT-1:0] virt,
                                       input logic [pin_select_pkg::N_INT-1:0] ints);
    logic [7:0] ofs;
    ofs = 8'h00;
    index_level = 1'b0;
    if (idx <= pin_select_pkg::IDX_INT_HI) begin
      index_level = ints[idx[3:0]] & (idx != 8'h00);                   // Index 0 is ground
    end else if (idx >= pin_select_pkg::IDX_PIN_LO && idx <= pin_select_pkg::IDX_PIN_HI) begin
      ofs = idx - pin_select_pkg::IDX_PIN_LO;
      index_level = pins[ofs[2:0]];
    end else if (idx >= pin_select_pkg::IDX_VIRT_LO && idx <= pin_select_pkg::IDX_VIRT_HI) begin
      ofs = idx - pin_select_pkg::IDX_VIRT_LO;
      index_level = virt[ofs[2:0]];                                    // [R16]
    end
  endfunction : index_level

  // ==========================================================================
  // AHB-Lite slave
  // Writes finish with no wait state; reads take one wait so hrdata comes from a flop
  assign accept    = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_wait_reg;
  assign hresp     = 1'b0;                                             // [R07]
  assign hrdata    = hrdata_reg;
  assign wr_en     = dp_reg.valid & dp_reg.write;
  assign sel_idx   = dp_reg.addr[pin_select_pkg::SEL_IDX_LSB +: 2];
  assign sel_hit_in  = (dp_reg.addr & pin_select_pkg::OFS_SEL_MSK) == pin_select_pkg::OFS_INSEL;
  assign sel_hit_out = (dp_reg.addr & pin_select_pkg::OFS_SEL_MSK) == pin_select_pkg::OFS_OUTSEL;
  assign key_byte  = hwdata[7:0];

  // Address phase capture; held while a read waits since hready is low then
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_reg <= '0;
    end else if (hready) begin
      dp_reg.valid <= accept;
      dp_reg.write <= hwrite;
      dp_reg.addr  <= {haddr[7:2], 2'b00};
    end
  end

  // Read wait flag, high for exactly the first data phase cycle of a read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait_reg <= 1'b0;
    end else begin
      rd_wait_reg <= accept & ~hwrite;
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (dp_reg.addr == pin_select_pkg::OFS_CONTROL) begin
      rdata_next[pin_select_pkg::LOCK_BIT] = lock_reg;
      rdata_next[2:0] = seq_reg;
    end else if (dp_reg.addr == pin_select_pkg::OFS_PINS) begin
      rdata_next[pin_select_pkg::N_PINS-1:0] = pin_in;
    end else if (sel_hit_in) begin
      rdata_next[15:0] = insel_reg[sel_idx];
    end else if (sel_hit_out) begin
      rdata_next[15:0] = outsel_reg[sel_idx];
    end
  end

  // Read data register, loaded during the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_wait_reg) begin
      hrdata_reg <= rdata_next;
    end
  end

  // ==========================================================================
  // Unlock sequence and lock bit
  // Only bus writes advance or abort the sequence; reads in between are harmless
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_reg <= pin_select_pkg::SEQ_IDLE;
    end else if (wr_en) begin
      case (seq_reg)
        pin_select_pkg::SEQ_IDLE: begin
          if (dp_reg.addr == pin_select_pkg::OFS_KEY && key_byte == pin_select_pkg::KEY_FIRST) begin
            seq_reg <= pin_select_pkg::SEQ_KEY1;                       // [R09]
          end
        end
        pin_select_pkg::SEQ_KEY1: begin
          if (dp_reg.addr == pin_select_pkg::OFS_KEY && key_byte == pin_select_pkg::KEY_SECOND) begin
            seq_reg <= pin_select_pkg::SEQ_ARMED;                      // [R09]
          end else if (dp_reg.addr == pin_select_pkg::OFS_KEY && key_byte == pin_select_pkg::KEY_FIRST) begin
            seq_reg <= pin_select_pkg::SEQ_KEY1;
          end else begin
            seq_reg <= pin_select_pkg::SEQ_IDLE;                       // [R17]
          end
        end
        pin_select_pkg::SEQ_ARMED: begin
          seq_reg <= pin_select_pkg::SEQ_IDLE;                         // One write only [R17]
        end
        default: begin
          seq_reg <= pin_select_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Lock changes only on a control write right after both keys; else it holds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_reg <= 1'b0;                                                // [R12]
    end else if (wr_en && seq_reg == pin_select_pkg::SEQ_ARMED &&
                 dp_reg.addr == pin_select_pkg::OFS_CONTROL) begin
      lock_reg <= hwdata[pin_select_pkg::LOCK_BIT];                    // [R08] [R09] [R10]
    end
  end

  // ==========================================================================
  // Select registers
  // A locked write still answers OKAY; only the store is suppressed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < pin_select_pkg::N_SEL_REGS; i++) begin
        insel_reg[i] <= pin_select_pkg::INSEL_RESET;                   // [R11]
      end
    end else if (wr_en && sel_hit_in && !lock_reg) begin
      insel_reg[sel_idx] <= hwdata[15:0];                              // [R07] [R08] [R13]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < pin_select_pkg::N_SEL_REGS; i++) begin
        outsel_reg[i] <= pin_select_pkg::OUTSEL_RESET;                 // [R11]
      end
    end else if (wr_en && sel_hit_out && !lock_reg) begin
      outsel_reg[sel_idx] <= hwdata[15:0];                             // [R07] [R08]
    end
  end

  // ==========================================================================
  // Input routing: each peripheral input picks its source by index
  // Dedicated-pad and analog modules have no select field here at all [R06]
  always_comb begin
    for (int k = 0; k < pin_select_pkg::N_INPUTS; k++) begin
      periph_in_next[k] = index_level(field_of(insel_reg[k / 2], k), pin_in, virt_in, internal_sig); // [R01] [R02]
    end
  end

  // Output routing: analog first, then a remapped peripheral, then the fixed function
  always_comb begin
    logic [7:0] sel;
    logic [7:0] code;
    sel  = 8'h00;
    code = 8'h00;
    for (int p = 0; p < pin_select_pkg::N_PINS; p++) begin
      sel  = field_of(outsel_reg[p / 2], p);
      code = sel - 8'h01;
      if (analog_en[p]) begin
        pin_out_next[p] = 1'b0;                                        // [R05]
        pin_oe_next[p]  = 1'b0;
      end else if (sel != pin_select_pkg::OUT_NULL && sel <= 8'(pin_select_pkg::N_PERIPH)) begin
        pin_out_next[p] = periph_out[code[2:0]];                       // [R01] [R04]
        pin_oe_next[p]  = periph_oe[code[2:0]];
      end else begin
        pin_out_next[p] = default_out[p];                              // [R03]
        pin_oe_next[p]  = default_oe[p];
      end
    end
  end

  // Registered pad and peripheral side outputs; one cycle of latency by design
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_in <= '0;
      pin_out   <= '0;
      pin_oe    <= '0;
    end else begin
      periph_in <= periph_in_next;
      pin_out   <= pin_out_next;
      pin_oe    <= pin_oe_next;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_locked_insel: assert property (wr_en && sel_hit_in && lock_reg |=> insel_reg[$past(sel_idx)] == $past(insel_reg[sel_idx])) // [R07]
    else $error("Input select changed while locked");
  a_locked_outsel: assert property (wr_en && sel_hit_out && lock_reg |=> outsel_reg[$past(sel_idx)] == $past(outsel_reg[sel_idx])) // [R07]
    else $error("Output select changed while locked");
  a_lock_needs_key: assert property ($changed(lock_reg) |-> $past(seq_reg) == pin_select_pkg::SEQ_ARMED) // [R09]
    else $error("Lock changed without key sequence");
  a_lock_follows_bit: assert property (wr_en && seq_reg == pin_select_pkg::SEQ_ARMED && dp_reg.addr == pin_select_pkg::OFS_CONTROL |=> lock_reg == $past(hwdata[pin_select_pkg::LOCK_BIT])) // [R08]
    else $error("Lock did not take written bit 11");
  a_seq_abort: assert property (wr_en && seq_reg == pin_select_pkg::SEQ_KEY1 && dp_reg.addr != pin_select_pkg::OFS_KEY |=> seq_reg == pin_select_pkg::SEQ_IDLE) // [R17]
    else $error("Intervening write did not abort sequence");
  a_analog_wins: assert property (analog_en[0] |=> !pin_oe[0] && !pin_out[0]) // [R05]
    else $error("Digital drive on analog pin");
  a_remap_override: assert property (!analog_en[0] && field_of(outsel_reg[0], 0) == 8'h01 |=> pin_out[0] == $past(periph_out[0]) && pin_oe[0] == $past(periph_oe[0])) // [R04]
    else $error("Remapped output not on pin");
  a_default_pin: assert property (!analog_en[1] && field_of(outsel_reg[0], 1) == pin_select_pkg::OUT_NULL |=> pin_oe[1] == $past(default_oe[1])) // [R03]
    else $error("Fixed function lost its pin");
  a_reserved_low: assert property (field_of(insel_reg[0], 0) == 8'hFF |=> !periph_in[0]) // [R11]
    else $error("Unmapped input not tied low");
  a_virtual_pin: assert property (field_of(insel_reg[0], 1) == pin_select_pkg::IDX_VIRT_LO |=> periph_in[1] == $past(virt_in[0])) // [R16]
    else $error("Virtual pin not routed");
  a_read_wait: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state wrong");

  c_lock_set: cover property (wr_en && seq_reg == pin_select_pkg::SEQ_ARMED ##1 lock_reg);
  c_locked_write: cover property (wr_en && sel_hit_in && lock_reg);
  c_seq_abort: cover property (seq_reg == pin_select_pkg::SEQ_KEY1 ##1 seq_reg == pin_select_pkg::SEQ_IDLE);
  c_remap_active: cover property (pin_oe[0] && field_of(outsel_reg[0], 0) != pin_select_pkg::OUT_NULL);

endmodule : remappable_pin_select

// >>> verification/periph_pad_model.sv
// Behavioural model of the peripherals and pads around the pin select block
`timescale 1ns/1ps
module periph_pad_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        load,
  input  wire logic [67:0] pattern,
  output logic      [7:0]  pin_in,
  output logic      [5:0]  virt_in,
  output logic      [13:0] internal_sig,
  output logic      [7:0]  periph_out,
  output logic      [7:0]  periph_oe,
  output logic      [7:0]  default_out,
  output logic      [7:0]  default_oe,
  output logic      [7:0]  analog_en
);
  // ==========================================================================
  // Pad levels and peripheral drive
  // New levels land only on a load edge, so the bench always knows what the block sees
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {analog_en, default_oe, default_out, periph_oe, periph_out, internal_sig, virt_in, pin_in} <= '0;
    end else if (load) begin
      {analog_en, default_oe, default_out, periph_oe, periph_out, internal_sig, virt_in, pin_in} <= pattern;
    end
  end
endmodule : periph_pad_model

// >>> verification/remappable_pin_select_tb_top.sv
// Self-checking bench for the remappable pin select block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module remappable_pin_select_tb_top;
  logic        hclk, hresetn, hsel, hwrite, load, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [7:0]  pin_in, pin_out, pin_oe, default_out, default_oe, analog_en, periph_out, periph_oe, periph_in;
  logic [5:0]  virt_in;
  logic [13:0] internal_sig;
  logic [67:0] pattern;
  logic [7:0]  in_sel [8];
  logic [7:0]  out_sel [8];
  int          errors, cmp_count;

  remappable_pin_select DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .default_out(default_out), .default_oe(default_oe), .analog_en(analog_en), .virt_in(virt_in),
    .internal_sig(internal_sig), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in));
  periph_pad_model partner (.hclk(hclk), .hresetn(hresetn), .load(load), .pattern(pattern), .pin_in(pin_in),
    .virt_in(virt_in), .internal_sig(internal_sig), .periph_out(periph_out), .periph_oe(periph_oe),
    .default_out(default_out), .default_oe(default_oe), .analog_en(analog_en));

  // ==========================================================================
  // Clock, verdict and watchdog
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task final_report;
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // Far longer than the whole sequence needs
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    final_report();
  end

  // ==========================================================================
  // Stimulus helpers and expectations
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Mix of ground, internal, physical, virtual and reserved indices
  function automatic logic [7:0] rnd_idx(input logic [31:0] r);
    case (r[1:0])
      2'h0: return 8'(r[15:8] % 8'h0E);
      2'h1: return pin_select_pkg::IDX_PIN_LO + 8'(r[15:8] % 8'h08);
      2'h2: return pin_select_pkg::IDX_VIRT_LO + 8'(r[15:8] % 8'h06);
      default: return r[8] ? 8'hFF : 8'h0E + 8'(r[15:8] % 8'h12);
    endcase
  endfunction : rnd_idx
  function automatic logic exp_in(input logic [7:0] idx);
    if (idx >= 8'h01 && idx <= pin_select_pkg::IDX_INT_HI) return internal_sig[idx[3:0]];
    if (idx >= pin_select_pkg::IDX_PIN_LO && idx <= pin_select_pkg::IDX_PIN_HI) return pin_in[idx[2:0]];
    if (idx >= pin_select_pkg::IDX_VIRT_LO && idx <= pin_select_pkg::IDX_VIRT_HI)
      return virt_in[3'(idx - pin_select_pkg::IDX_VIRT_LO)];
    return 1'b0;
  endfunction : exp_in
  // Ready is looked at mid-cycle, so the value seen is the one the next rising edge samples
  // No cycle budget here: only the watchdog ends a wait that never completes
  task wait_rdy;
    @(negedge hclk);
    while (hreadyout !== 1'b1) begin
      @(negedge hclk);
    end
    rd = hrdata;
    @(posedge hclk);
  endtask : wait_rdy
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    `CHK("hresp", 1'b0, hresp)
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(nm, ex, rd)
  endtask : rdchk
  task key_seq(input logic [31:0] ctrl);
    wr(pin_select_pkg::OFS_KEY, 32'h0000_0055);
    wr(pin_select_pkg::OFS_KEY, 32'h0000_00AA);
    wr(pin_select_pkg::OFS_CONTROL, ctrl);
  endtask : key_seq
  task do_reset;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset
  // Writes every select register, then hands the partner fresh random levels
  task apply;
    logic [31:0] r1, r2, r3;
    for (int n = 0; n < 4; n++) begin
      wr(pin_select_pkg::OFS_INSEL + 8'(4 * n), {16'h0000, in_sel[2*n+1], in_sel[2*n]});
      wr(pin_select_pkg::OFS_OUTSEL + 8'(4 * n), {16'h0000, out_sel[2*n+1], out_sel[2*n]});
    end
    r1 = rnd();
    r2 = rnd();
    r3 = rnd();
    pattern <= {r3[3:0], r2, r1};
    load    <= 1'b1;
    @(posedge hclk);
    load <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : apply
  task check_map;
    logic [7:0] ei, eo, ee;
    @(negedge hclk);
    for (int i = 0; i < 8; i++) begin
      ei[i] = exp_in(in_sel[i]);
      eo[i] = default_out[i];
      ee[i] = default_oe[i];
      if (out_sel[i] >= 8'h01 && out_sel[i] <= 8'h08) begin
        eo[i] = periph_out[3'(out_sel[i] - 8'h01)];
        ee[i] = periph_oe[3'(out_sel[i] - 8'h01)];
      end
      if (analog_en[i]) {eo[i], ee[i]} = 2'b00;
    end
    `CHK("periph_in", ei, periph_in)
    `CHK("pin_out", eo, pin_out)
    `CHK("pin_oe", ee, pin_oe)
    @(posedge hclk);
  endtask : check_map
  task park;
    for (int i = 0; i < 8; i++) begin
      in_sel[i]  = 8'hFF;
      out_sel[i] = 8'h00;
    end
  endtask : park

  // ==========================================================================
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, load, htrans, haddr, hwdata, pattern} = '0;
    errors = 0;
    cmp_count = 0;
    seed = 32'h0000_0029;
    park();
    do_reset();
    rdchk("ctrl", pin_select_pkg::OFS_CONTROL, 32'h0000_0001);
    for (int n = 0; n < 4; n++) begin
      rdchk("insel", pin_select_pkg::OFS_INSEL + 8'(4 * n), 32'h0000_FFFF);
      rdchk("outsel", pin_select_pkg::OFS_OUTSEL + 8'(4 * n), 32'h0000_0000);
    end
    apply();
    check_map();
    // Corner: every virtual pin and every peripheral output code
    for (int i = 0; i < 8; i++) begin
      in_sel[i]  = pin_select_pkg::IDX_VIRT_LO + 8'((i + 5) % 6);
      out_sel[i] = 8'(i + 1);
    end
    apply();
    check_map();
    rdchk("pins", pin_select_pkg::OFS_PINS, {24'h00_0000, pin_in});
    repeat (12) begin
      for (int i = 0; i < 8; i++) begin
        in_sel[i]  = rnd_idx(rnd());
        out_sel[i] = 8'(rnd() % 11);
      end
      apply();
      check_map();
      rdchk("insel0", pin_select_pkg::OFS_INSEL, {16'h0000, in_sel[1], in_sel[0]});
    end
    // Key sequence, with reads between the keys
    wr(pin_select_pkg::OFS_KEY, 32'h0000_0055);
    rdchk("seq_key1", pin_select_pkg::OFS_CONTROL, 32'h0000_0002);
    rdchk("seq_key1b", pin_select_pkg::OFS_CONTROL, 32'h0000_0002);
    wr(pin_select_pkg::OFS_KEY, 32'h0000_00AA);
    rdchk("seq_armed", pin_select_pkg::OFS_CONTROL, 32'h0000_0004);
    wr(pin_select_pkg::OFS_CONTROL, 32'h0000_0800);
    rdchk("locked", pin_select_pkg::OFS_CONTROL, 32'h0000_0801);
    // Locked writes complete but change nothing, over one input select and one output select write
    wr(pin_select_pkg::OFS_INSEL, 32'h0000_2121);
    wr(pin_select_pkg::OFS_OUTSEL + 8'h04, 32'h0000_0303);
    // Read back before apply rewrites the same values and would hide a leak
    rdchk("insel_kept", pin_select_pkg::OFS_INSEL, {16'h0000, in_sel[1], in_sel[0]});
    rdchk("outsel_kept", pin_select_pkg::OFS_OUTSEL + 8'h04, {16'h0000, out_sel[3], out_sel[2]});
    apply();
    check_map();
    // A bare control write, then a sequence broken by another write
    wr(pin_select_pkg::OFS_CONTROL, 32'h0000_0000);
    wr(pin_select_pkg::OFS_KEY, 32'h0000_0055);
    wr(pin_select_pkg::OFS_INSEL, 32'h0000_0000);
    wr(pin_select_pkg::OFS_KEY, 32'h0000_00AA);
    wr(pin_select_pkg::OFS_CONTROL, 32'h0000_0000);
    rdchk("still_locked", pin_select_pkg::OFS_CONTROL, 32'h0000_0801);
    // A repeated first key restarts; a stray write while armed aborts
    wr(pin_select_pkg::OFS_KEY, 32'h0000_0055);
    wr(pin_select_pkg::OFS_KEY, 32'h0000_0055);
    wr(pin_select_pkg::OFS_KEY, 32'h0000_00AA);
    rdchk("seq_rearmed", pin_select_pkg::OFS_CONTROL, 32'h0000_0804);
    wr(pin_select_pkg::OFS_KEY, 32'h0000_0000);
    wr(pin_select_pkg::OFS_CONTROL, 32'h0000_0000);
    rdchk("armed_abort", pin_select_pkg::OFS_CONTROL, 32'h0000_0801);
    // Reset in mid-run while locked with a live mapping
    do_reset();
    rdchk("ctrl_rst", pin_select_pkg::OFS_CONTROL, 32'h0000_0001);
    rdchk("insel_rst", pin_select_pkg::OFS_INSEL, 32'h0000_FFFF);
    // Software parks unused selections, then relocks
    park();
    apply();
    check_map();
    key_seq(32'h0000_0800);
    rdchk("relocked", pin_select_pkg::OFS_CONTROL, 32'h0000_0801);
    key_seq(32'h0000_0000);
    rdchk("unlocked", pin_select_pkg::OFS_CONTROL, 32'h0000_0001);
    // Unmapped offset reads zero and ignores writes
    wr(8'h30, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h30, 32'h0000_0000);
    final_report();
  end
endmodule : remappable_pin_select_tb_top
